// File: hdl/tra_pkg.sv
package tra_pkg;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int unsigned  FUNC_W        = 4;
	localparam int unsigned  BIT_MODE      = 3;
	localparam int unsigned  BIT_SRC       = 2;
	localparam logic [3:0]   FUNC_RST      = 4'h0;
	localparam logic [1:0]   ACT_NONE      = 2'h0;
	localparam logic [1:0]   ACT_LOW       = 2'h1;
	localparam logic [1:0]   ACT_HIGH      = 2'h2;
	localparam logic [1:0]   ACT_TOGGLE    = 2'h3;
	localparam logic [1:0]   EDGE_RISE     = 2'h0;
	localparam logic [1:0]   EDGE_FALL     = 2'h1;
	localparam int unsigned  CH_ONE        = 1;
	localparam int unsigned  CH_TWO        = 2;

	typedef enum logic [1:0] {
		TRA_MODE_CMP    = 2'b00,
		TRA_MODE_CMP_B  = 2'b01,
		TRA_MODE_PIN    = 2'b10,
		TRA_MODE_CH0    = 2'b11
	} tra_mode_t;

	// Pin level and enable
	typedef struct packed {
		logic  out;
		logic  oe;
	} tra_pin_t;

endpackage : tra_pkg

// File: hdl/tra_edge.sv
module tra_edge (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        pin_i,
	input  wire logic [1:0]  sel_i,
	output logic             hit_o
);
	logic pin_q;
	logic pin_d;

	always_comb begin
		pin_d = pin_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

	always_comb begin
		if (sel_i[1]) begin
			hit_o = pin_i ^ pin_q;
		end else if (sel_i[0]) begin
			hit_o = pin_q & ~pin_i;
		end else begin
			hit_o = ~pin_q & pin_i;
		end
	end

endmodule : tra_edge

// File: hdl/tra_ioa.sv
module tra_ioa #(
	parameter int unsigned CNT_W   = 16,
	parameter int unsigned CHANNEL = 1
) (
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic [3:0]        FUNC_I,
	input  wire logic              FUNC_WE_I,
	input  wire logic [CNT_W-1:0]  COUNT_I,
	input  wire logic              MATCH_I,
	input  wire logic              PIN_I,
	input  wire logic              CH0_EVENT_I,
	output logic      [3:0]        FUNC_O,
	output logic                   PIN_O,
	output logic                   PIN_OE_O,
	output logic                   IS_CAPTURE_O,
	output logic                   CAPTURE_O,
	output logic      [CNT_W-1:0]  REG_A_O
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Function field
	// ------------------------------------------------------------
	logic [3:0]          func_q;
	logic [3:0]          func_d;
	tra_pkg::tra_mode_t  mode;
	logic [1:0]          act;

	always_comb begin
		func_d = FUNC_WE_I ? FUNC_I : func_q;
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			func_q <= tra_pkg::FUNC_RST;
		end else begin
			func_q <= func_d;
		end
	end

	assign mode = tra_pkg::tra_mode_t'(func_q[tra_pkg::BIT_MODE -: 2]);
	assign act  = func_q[1:0];

	// ------------------------------------------------------------
	// Capture event select
	// ------------------------------------------------------------
	logic pin_hit;
	logic cap_ev;

	tra_edge u_edge (
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.pin_i   (PIN_I),
		.sel_i   (act),
		.hit_o   (pin_hit)
	);

	always_comb begin
		case (mode)
			tra_pkg::TRA_MODE_PIN: cap_ev = pin_hit;
			tra_pkg::TRA_MODE_CH0: begin
				// Only channel 1 chains from channel 0; elsewhere pin source
				if (CHANNEL == tra_pkg::CH_ONE) begin
					cap_ev = CH0_EVENT_I;
				end else begin
					cap_ev = pin_hit;
				end
			end
			default: cap_ev = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Pin output and register A
	// ------------------------------------------------------------
	logic              pin_q;
	logic              pin_d;
	logic              oe_q;
	logic              oe_d;
	logic [CNT_W-1:0]  rega_q;
	logic [CNT_W-1:0]  rega_d;
	logic              cmp;
	// Restart flag: the new code only shows in func_q one cycle after the
	// write, so the initial level must be taken from func_q then, not from
	// the code that was being replaced.
	logic              restart_q;
	logic              restart_d;

	assign cmp = ~func_q[tra_pkg::BIT_MODE];

	always_comb begin
		pin_d  = pin_q;
		oe_d   = oe_q;
		rega_d = rega_q;
		restart_d = FUNC_WE_I;
		if (cmp) begin
			if (act == tra_pkg::ACT_NONE) begin
				oe_d = 1'b0;
			end else if (FUNC_WE_I || restart_q || !oe_q) begin
				// Output begins at the initial level when a code is armed
				oe_d  = 1'b1;
				pin_d = func_q[tra_pkg::BIT_SRC];
			end else if (MATCH_I) begin
				case (act)
					tra_pkg::ACT_LOW:    pin_d = 1'b0;
					tra_pkg::ACT_HIGH:   pin_d = 1'b1;
					tra_pkg::ACT_TOGGLE: pin_d = ~pin_q;
					default:             pin_d = pin_q;
				endcase
			end
		end else begin
			oe_d = 1'b0;
			if (cap_ev) begin
				rega_d = COUNT_I;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pin_q     <= 1'b0;
			oe_q      <= 1'b0;
			rega_q    <= '0;
			restart_q <= 1'b0;
		end else begin
			pin_q     <= pin_d;
			oe_q      <= oe_d;
			rega_q    <= rega_d;
			restart_q <= restart_d;
		end
	end

	assign FUNC_O       = func_q;
	assign PIN_O        = pin_q;
	assign PIN_OE_O     = oe_q;
	assign IS_CAPTURE_O = func_q[tra_pkg::BIT_MODE];
	assign CAPTURE_O    = ~cmp & cap_ev;
	assign REG_A_O      = rega_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_RESET_ZERO: assert property (@(posedge CLK_I) !rst_n |=> func_q == 4'h0 || $past(FUNC_WE_I))
		else $error("field not zero after reset");
	AST_DISABLED: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(cmp && act == 2'h0) |=> !PIN_OE_O)
		else $error("pin enabled with code 00");
	AST_LOW: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q[3] == 1'b0 && act == 2'h1 && oe_q && MATCH_I && !FUNC_WE_I && !restart_q)
		|=> !PIN_O)
		else $error("no low on match");
	AST_HIGH: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q[3] == 1'b0 && act == 2'h2 && oe_q && MATCH_I && !FUNC_WE_I && !restart_q)
		|=> PIN_O)
		else $error("no high on match");
	AST_TOGGLE: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q[3] == 1'b0 && act == 2'h3 && oe_q && MATCH_I && !FUNC_WE_I && !restart_q)
		|=> PIN_O != $past(PIN_O))
		else $error("no toggle on match");
	AST_RISE: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q == 4'h8 && !$past(PIN_I) && PIN_I) |-> CAPTURE_O)
		else $error("rising edge missed");
	AST_FALL: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q == 4'h9 && $past(PIN_I) == PIN_I) |-> !CAPTURE_O)
		else $error("capture without edge");
	AST_BOTH: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(func_q[3:1] == 3'h5 && $past(PIN_I) != PIN_I) |-> CAPTURE_O)
		else $error("edge missed in both mode");
	AST_VALUE: assert property (@(posedge CLK_I) disable iff (!rst_n)
		CAPTURE_O |=> REG_A_O == $past(COUNT_I))
		else $error("captured value wrong");

	// ------------------------------------------------------------
	// Multi-step checks
	// ------------------------------------------------------------
	// Arming: new compare code with an action, first cycle it is live
	sequence s_arm;
		cmp && act != tra_pkg::ACT_NONE && restart_q && !FUNC_WE_I;
	endsequence

	// Output enabled at the level chosen by bit 2
	sequence s_start_level;
		PIN_OE_O && PIN_O == $past(func_q[tra_pkg::BIT_SRC]);
	endsequence

	// Rising edge on the pin, seen against the previous sample
	sequence s_pin_rise;
		!$past(PIN_I) && PIN_I;
	endsequence

	AST_INIT: assert property (@(posedge CLK_I) disable iff (!rst_n)
		s_arm |=> s_start_level)
		else $error("initial level wrong");

	AST_CH0: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(CHANNEL == tra_pkg::CH_ONE && func_q[3:2] == 2'h3) |-> CAPTURE_O == CH0_EVENT_I)
		else $error("channel 0 event not followed");

	// Channel 2 takes its own pin even with the chained code
	AST_CH2_PIN: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(CHANNEL == tra_pkg::CH_TWO && func_q[3] && func_q[1:0] == 2'h0)
		##0 s_pin_rise |-> CAPTURE_O)
		else $error("own pin edge missed");

	AST_NO_CAP_CMP: assert property (@(posedge CLK_I) disable iff (!rst_n)
		!func_q[3] |-> !CAPTURE_O)
		else $error("capture in compare mode");

	AST_OE_CAP: assert property (@(posedge CLK_I) disable iff (!rst_n)
		func_q[3] |=> !PIN_OE_O)
		else $error("pin driven in capture mode");

	AST_HOLD: assert property (@(posedge CLK_I) disable iff (!rst_n)
		!CAPTURE_O |=> $stable(REG_A_O))
		else $error("register changed without capture");

endmodule : tra_ioa

// File: tb/tra_far.sv
module tra_far (
	input  wire logic clk_i,
	input  wire logic pin_req_i,
	input  wire logic ev_req_i,
	output logic      pin_o,
	output logic      ev_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ev_q;
	logic ev_p;
	// -------------------------------------------------------------
	// Pin and channel 0 source
	// -------------------------------------------------------------
	// Pin moves one edge after the request, as a synchronised input would
	always_ff @(posedge clk_i) begin
		pin_o <= pin_req_i;
		ev_q  <= ev_req_i;
		ev_p  <= ev_q;
	end
	// One-cycle event for each toggle of the request
	assign ev_o = ev_q ^ ev_p;
endmodule : tra_far

// File: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst_n, we, match, pin_req, ev_req, pin, ev;
	logic [3:0]  func, f1, f2;
	logic [15:0] cnt = 16'h005B;
	logic [15:0] r1, r2;
	logic        p1, p2, oe1, oe2, ic1, ic2, c1, c2;
	int          n_errors = 0;
	int          checked = 0;
	always #10 clk = ~clk;
	// Counter value is random so a stale capture cannot match by luck
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	always @(posedge clk) cnt <= lfsr(cnt);
	tra_far tra_far_i (.clk_i(clk), .pin_req_i(pin_req), .ev_req_i(ev_req), .pin_o(pin), .ev_o(ev));
	tra_ioa #(.CNT_W(16), .CHANNEL(1)) tra_ioa_i (.CLK_I(clk), .RST_N_I(rst_n), .FUNC_I(func),
		.FUNC_WE_I(we), .COUNT_I(cnt), .MATCH_I(match), .PIN_I(pin), .CH0_EVENT_I(ev),
		.FUNC_O(f1), .PIN_O(p1), .PIN_OE_O(oe1), .IS_CAPTURE_O(ic1), .CAPTURE_O(c1), .REG_A_O(r1));
	tra_ioa #(.CNT_W(16), .CHANNEL(2)) tra_ioa_two_i (.CLK_I(clk), .RST_N_I(rst_n), .FUNC_I(func),
		.FUNC_WE_I(we), .COUNT_I(cnt), .MATCH_I(match), .PIN_I(pin), .CH0_EVENT_I(ev),
		.FUNC_O(f2), .PIN_O(p2), .PIN_OE_O(oe2), .IS_CAPTURE_O(ic2), .CAPTURE_O(c2), .REG_A_O(r2));
	// -------------------------------------------------------------
	// Checking helpers
	// -------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] c);
		@(posedge clk); func <= c; we <= 1'b1;
		@(posedge clk); we <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("func", {c, c}, {f2, f1});
	endtask : wr
	// Event 0 rising pin, 1 falling pin, 2 channel 0 event
	function automatic logic hit(input int ch, input logic [3:0] c, input int e);
		if (ch == 1 && c[3:2] == 2'h3) return e == 2;
		if (e == 2) return 1'b0;
		if (c[1]) return 1'b1;
		return c[0] ? e == 1 : e == 0;
	endfunction : hit
	task automatic cmp_case(input logic [3:0] c);
		logic e;
		wr(c);
		e = c[2];
		chk("oe", {2{c[1:0] != 2'h0}}, {oe2, oe1});
		chk("is_cap", 16'h0, {ic2, ic1});
		if (c[1:0] != 2'h0) chk("init", {2{e}}, {p2, p1});
		repeat (2) begin
			@(posedge clk); match <= 1'b1;
			@(posedge clk); match <= 1'b0;
			@(posedge clk); #1;
			e = (c[1:0] == tra_pkg::ACT_TOGGLE) ? ~e : c[1];
			if (c[1:0] != 2'h0) chk("match", {2{e}}, {p2, p1});
		end
	endtask : cmp_case
	task automatic cap_case(input logic [3:0] c);
		logic [15:0] v;
		logic        h1, h2;
		wr(c);
		chk("is_cap", 16'h3, {ic2, ic1});
		for (int e = 0; e < 3; e++) begin
			@(posedge clk);
			if (e < 2) pin_req <= (e == 0);
			else ev_req <= ~ev_req;
			@(posedge clk); #1;
			h1 = hit(1, c, e);
			h2 = hit(2, c, e);
			v = cnt;
			chk("capture", {h2, h1}, {c2, c1});
			@(posedge clk); #1;
			if (h1) chk("reg1", v, r1);
			if (h2) chk("reg2", v, r2);
		end
	endtask : cap_case
	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		rst_n = 1'b0; we = 1'b0; match = 1'b0; pin_req = 1'b0; ev_req = 1'b0; func = 4'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("reset", 16'h0, {oe2, oe1, f2, f1});
		for (int c = 0; c < 8; c++) cmp_case(c[3:0]);
		for (int c = 8; c < 16; c++) cap_case(c[3:0]);
		report_and_stop;
	end
	initial begin
		#200000;
		n_errors++;
		report_and_stop;
	end
endmodule : testbench
